// *** design/general_purpose_timer.sv ***
`timescale 1ns/10ps
// Summary of operation
// - Full timer: 16-bit reload counter, up/down/center
// - Prescaler divides by 1 through 65536
// - Full timer: four capture/compare/PWM/one-pulse channels
// - Reduced timer: same counter, two channels
// - DMA requests only on the full timer
// - Link trigger in/out synchronizes or chains timers
// - Counter freezes during debug halt when selected
// - Full timer decodes quadrature and hall inputs
// - Reduced timer counts low-speed oscillator edges
module general_purpose_timer #(
  parameter bit FULL = 1'b1
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Clock sources, debug and link
  input  wire logic        i_low_speed_ext_osc,
  input  wire logic        i_dbg_halt,
  input  wire logic        i_link_trg,
  output logic             o_link_trgo,
  // Channels and requests
  input  wire logic [3:0]  i_ch_in,
  output logic      [3:0]  o_ch_out,
  output logic             o_dma_req,
  output logic             o_update_flag
);

  localparam int NCH = FULL ? gp_timer_pkg::FULL_CH : gp_timer_pkg::REDUCED_CH;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  gp_timer_pkg::ctrl_t ctrl,      next_ctrl;
  logic [15:0]         presc,     next_presc;
  logic [15:0]         reload,    next_reload;
  logic [7:0]          chmode,    next_chmode;
  logic [15:0]         ccr       [gp_timer_pkg::MAX_CH];
  logic [15:0]         next_ccr  [gp_timer_pkg::MAX_CH];
  logic                dma_en,    next_dma_en;
  logic                upd_flag,  next_upd_flag;
  logic [3:0]          ch_flag,   next_ch_flag;
  logic [31:0]         next_prdata;
  logic                next_pready;
  logic                next_pslverr;
  logic [15:0]         cnt,       next_cnt;
  logic [15:0]         psc_cnt,   next_psc_cnt;
  logic                dir_down,  next_dir_down;
  logic                lso_q;
  logic [3:0]          in_q;
  logic                hall_q;
  logic                next_trgo;
  logic                next_dma;
  logic                src_tick;
  logic                tick;
  logic                upd;
  logic                run;
  logic                enc_up;
  logic                cnt_wr;
  logic                wr;
  logic [3:0]          cap_ev;
  logic [3:0]          cmp_ev;
  logic [3:0]          next_out;

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] ccr_addr(input int c);
    ccr_addr = gp_timer_pkg::OFF_CCR0 + 8'(c) * gp_timer_pkg::CCR_STEP;
  endfunction

  // Channels beyond NCH and the DMA enable do not exist on a reduced timer
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == gp_timer_pkg::OFF_CTRL)   || (a == gp_timer_pkg::OFF_STATUS) ||
              (a == gp_timer_pkg::OFF_COUNT)  || (a == gp_timer_pkg::OFF_PRESC)  ||
              (a == gp_timer_pkg::OFF_RELOAD) || (a == gp_timer_pkg::OFF_CHMODE) ||
              (FULL && a == gp_timer_pkg::OFF_DMAEN);
    for (int c = 0; c < NCH; c++) begin
      if (a == ccr_addr(c)) begin
        reg_hit = 1'b1;
      end
    end
  endfunction

  assign wr     = i_psel & i_penable & o_pready & i_pwrite & reg_hit(i_paddr);
  assign cnt_wr = wr & (i_paddr == gp_timer_pkg::OFF_COUNT);

  // ----------------------------------------------------------------
  // Counter, prescaler and tick sources
  // ----------------------------------------------------------------
  // Encoder edges and link triggers pass the prescaler like any other source
  always_comb begin
    enc_up        = in_q[0] ^ i_ch_in[1];
    run           = ctrl.en & ~(ctrl.freeze & i_dbg_halt);
    case (ctrl.src)
      gp_timer_pkg::SRC_BUS:  src_tick = 1'b1;
      gp_timer_pkg::SRC_LSO:  src_tick = ~FULL & i_low_speed_ext_osc & ~lso_q;
      gp_timer_pkg::SRC_ENC:  src_tick = FULL & |(i_ch_in[1:0] ^ in_q[1:0]);
      gp_timer_pkg::SRC_LINK: src_tick = i_link_trg;
      default:                src_tick = 1'b0;
    endcase
    next_psc_cnt  = psc_cnt;
    tick          = 1'b0;
    if (run && src_tick) begin
      if (psc_cnt == presc) begin
        next_psc_cnt = 16'h0000;
        tick         = 1'b1;
      end else begin
        next_psc_cnt = psc_cnt + 16'h0001;
      end
    end
    // A new divider restarts the count; a smaller one would otherwise wait for a wrap
    if (wr && i_paddr == gp_timer_pkg::OFF_PRESC) begin
      next_psc_cnt = 16'h0000;
    end
    next_cnt      = cnt;
    next_dir_down = dir_down;
    upd           = 1'b0;
    if (cnt_wr) begin
      next_cnt = i_pwdata[15:0];
    end else if (run && ctrl.link_rst && i_link_trg) begin
      next_cnt     = 16'h0000;
      next_psc_cnt = 16'h0000;
    end else if (tick) begin
      if (ctrl.src == gp_timer_pkg::SRC_ENC) begin
        next_dir_down = ~enc_up;
      end else if (ctrl.mode == gp_timer_pkg::MODE_DOWN) begin
        next_dir_down = 1'b1;
      end else if (ctrl.mode != gp_timer_pkg::MODE_CENTER) begin
        next_dir_down = 1'b0;
      end
      if (!next_dir_down) begin
        if (cnt >= reload) begin
          upd = 1'b1;
          if (ctrl.mode == gp_timer_pkg::MODE_CENTER && ctrl.src != gp_timer_pkg::SRC_ENC) begin
            next_cnt      = reload - 16'h0001;
            next_dir_down = 1'b1;
          end else begin
            next_cnt = 16'h0000;
          end
        end else begin
          next_cnt = cnt + 16'h0001;
        end
      end else begin
        if (cnt == 16'h0000) begin
          upd = 1'b1;
          if (ctrl.mode == gp_timer_pkg::MODE_CENTER && ctrl.src != gp_timer_pkg::SRC_ENC) begin
            next_cnt      = 16'h0001;
            next_dir_down = 1'b0;
          end else begin
            next_cnt = reload;
          end
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
    end
    next_trgo = upd;
    next_dma  = FULL & dma_en & (upd | (|cap_ev) | (|cmp_ev));
  end

  // Counter registers; pin history feeds the edge detectors
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt         <= 16'h0000;
      psc_cnt     <= 16'h0000;
      dir_down    <= 1'b0;
      lso_q       <= 1'b0;
      in_q        <= 4'h0;
      hall_q      <= 1'b0;
      o_link_trgo <= 1'b0;
      o_dma_req   <= 1'b0;
    end else begin
      cnt         <= next_cnt;
      psc_cnt     <= next_psc_cnt;
      dir_down    <= next_dir_down;
      lso_q       <= i_low_speed_ext_osc;
      in_q        <= i_ch_in;
      hall_q      <= ^i_ch_in[2:0];
      o_link_trgo <= next_trgo;
      o_dma_req   <= next_dma;
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  // Unused hall inputs held low let one or two sensors work alone
  for (genvar c = 0; c < gp_timer_pkg::MAX_CH; c++) begin : g_ch
    if (c < NCH) begin : g_live
      gp_timer_pkg::ch_mode_t m;
      always_comb begin
        m         = gp_timer_pkg::ch_mode_t'(chmode[2*c +: 2]);
        cap_ev[c] = (m == gp_timer_pkg::CH_CAPTURE) &&
                    ((i_ch_in[c] && !in_q[c]) ||
                     (FULL && c == 0 && ctrl.hall && ((^i_ch_in[2:0]) != hall_q)));
        cmp_ev[c] = tick && (m != gp_timer_pkg::CH_CAPTURE) && (cnt == ccr[c]);
        case (m)
          gp_timer_pkg::CH_PWM:    next_out[c] = run && (next_cnt < ccr[c]);
          gp_timer_pkg::CH_TOGGLE: next_out[c] = o_ch_out[c] ^ cmp_ev[c];
          default:                 next_out[c] = 1'b0;
        endcase
      end
    end else begin : g_none
      assign cap_ev[c]   = 1'b0;
      assign cmp_ev[c]   = 1'b0;
      assign next_out[c] = 1'b0;
    end
  end

  // Channel output pins
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ch_out <= 4'h0;
    end else begin
      o_ch_out <= next_out;
    end
  end

  // ----------------------------------------------------------------
  // Register file and APB answer
  // ----------------------------------------------------------------
  // Read data is latched in the setup cycle, so pready can come from a flop
  always_comb begin
    next_ctrl     = ctrl;
    next_presc    = presc;
    next_reload   = reload;
    next_chmode   = chmode;
    next_dma_en   = dma_en;
    next_prdata   = o_prdata;
    next_pready   = i_psel & ~i_penable;
    next_pslverr  = i_psel & ~i_penable & ~reg_hit(i_paddr);
    for (int c = 0; c < gp_timer_pkg::MAX_CH; c++) begin
      next_ccr[c] = ccr[c];
      if (wr && i_paddr == ccr_addr(c)) begin
        next_ccr[c] = i_pwdata[15:0];
      end
      if (cap_ev[c]) begin
        next_ccr[c] = cnt;
      end
    end
    if (wr) begin
      case (i_paddr)
        gp_timer_pkg::OFF_CTRL:   next_ctrl   = gp_timer_pkg::ctrl_t'(i_pwdata[8:0]);
        gp_timer_pkg::OFF_PRESC:  next_presc  = i_pwdata[15:0];
        gp_timer_pkg::OFF_RELOAD: next_reload = i_pwdata[15:0];
        gp_timer_pkg::OFF_CHMODE: next_chmode = i_pwdata[7:0];
        gp_timer_pkg::OFF_DMAEN:  next_dma_en = i_pwdata[0];
        default:                  next_ctrl   = next_ctrl;
      endcase
    end
    if (upd && ctrl.one_pulse) begin
      next_ctrl.en = 1'b0;
    end
    // A new event beats a write-one-to-clear in the same cycle
    next_upd_flag = upd | (upd_flag &
                    ~(wr && i_paddr == gp_timer_pkg::OFF_STATUS && i_pwdata[0]));
    next_ch_flag  = cap_ev | cmp_ev | (ch_flag &
                    ~((wr && i_paddr == gp_timer_pkg::OFF_STATUS) ? i_pwdata[4:1] : 4'h0));
    if (i_psel && !i_penable) begin
      case (i_paddr)
        gp_timer_pkg::OFF_CTRL:   next_prdata = {23'h000000, ctrl};
        gp_timer_pkg::OFF_STATUS: next_prdata = {26'h0000000, dir_down, ch_flag, upd_flag};
        gp_timer_pkg::OFF_COUNT:  next_prdata = {16'h0000, cnt};
        gp_timer_pkg::OFF_PRESC:  next_prdata = {16'h0000, presc};
        gp_timer_pkg::OFF_RELOAD: next_prdata = {16'h0000, reload};
        gp_timer_pkg::OFF_CHMODE: next_prdata = {24'h000000, chmode};
        gp_timer_pkg::OFF_DMAEN:  next_prdata = {31'h00000000, dma_en & FULL};
        default:                  next_prdata = 32'h00000000;
      endcase
      for (int c = 0; c < NCH; c++) begin
        if (i_paddr == ccr_addr(c)) begin
          next_prdata = {16'h0000, ccr[c]};
        end
      end
    end
  end

  // Register file flops
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl          <= gp_timer_pkg::CTRL_RST;
      presc         <= gp_timer_pkg::PRESC_RST;
      reload        <= gp_timer_pkg::RELOAD_RST;
      chmode        <= gp_timer_pkg::CHMODE_RST;
      dma_en        <= 1'b0;
      upd_flag      <= 1'b0;
      ch_flag       <= 4'h0;
      o_prdata      <= 32'h00000000;
      o_pready      <= 1'b0;
      o_pslverr     <= 1'b0;
      for (int c = 0; c < gp_timer_pkg::MAX_CH; c++) begin
        ccr[c] <= 16'h0000;
      end
    end else begin
      ctrl          <= next_ctrl;
      presc         <= next_presc;
      reload        <= next_reload;
      chmode        <= next_chmode;
      dma_en        <= next_dma_en & FULL;
      upd_flag      <= next_upd_flag;
      ch_flag       <= next_ch_flag;
      o_prdata      <= next_prdata;
      o_pready      <= next_pready;
      o_pslverr     <= next_pslverr;
      for (int c = 0; c < gp_timer_pkg::MAX_CH; c++) begin
        ccr[c] <= next_ccr[c];
      end
    end
  end

  assign o_update_flag = upd_flag;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_setup;
    i_psel && !i_penable;
  endsequence

  a_tick_at_terminal: assert property (tick |-> psc_cnt == presc && run)
    else $error("Tick without prescaler terminal count");
  a_reload_up_wrap: assert property (tick && !cnt_wr && !next_dir_down && cnt == reload &&
      ctrl.mode == gp_timer_pkg::MODE_UP && !(ctrl.link_rst && i_link_trg)
      |=> cnt == 16'h0000 && upd_flag && o_link_trgo)
    else $error("Up count did not wrap with update");
  a_freeze_hold: assert property (ctrl.freeze && i_dbg_halt && !cnt_wr |=> $stable(cnt))
    else $error("Counter moved during debug halt");
  a_no_dma_reduced: assert property (!FULL |-> !o_dma_req && !dma_en)
    else $error("Reduced timer raised a DMA request");
  a_lso_edge_tick: assert property (ctrl.src == gp_timer_pkg::SRC_LSO && src_tick
      |-> !FULL && i_low_speed_ext_osc && !lso_q)
    else $error("Low-speed tick without oscillator edge");
  a_capture_value: assert property (cap_ev[0] |=> ccr[0] == $past(cnt) && ch_flag[0])
    else $error("Capture did not store the count");
  a_one_pulse_stop: assert property (upd && ctrl.one_pulse |=> !ctrl.en ##1 cnt == $past(cnt))
    else $error("One-pulse mode kept counting");
  a_flag_set_wins: assert property (upd |=> upd_flag [*2] or (upd_flag ##1 !upd_flag))
    else $error("Update flag lost its event");
  a_apb_ready: assert property (s_setup |=> o_pready ##1 !o_pready)
    else $error("APB answer not one cycle after setup");
  a_pwm_level: assert property (chmode[1:0] == 2'h2 |=> o_ch_out[0] == $past(run && next_cnt < ccr[0]))
    else $error("PWM output level wrong");

endmodule

// *** design/gp_timer_pkg.sv ***
package gp_timer_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_COUNT  = 8'h08;
  localparam logic [7:0] OFF_PRESC  = 8'h0c;
  localparam logic [7:0] OFF_RELOAD = 8'h10;
  localparam logic [7:0] OFF_CHMODE = 8'h14;
  localparam logic [7:0] OFF_CCR0   = 8'h18;
  localparam logic [7:0] CCR_STEP   = 8'h04;
  localparam logic [7:0] OFF_DMAEN  = 8'h28;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int          MAX_CH      = 4;
  localparam int          FULL_CH     = 4;
  localparam int          REDUCED_CH  = 2;
  localparam int          CTRL_W      = 9;
  localparam logic [15:0] RELOAD_RST  = 16'hffff;
  localparam logic [15:0] PRESC_RST   = 16'h0000;
  localparam logic [7:0]  CHMODE_RST  = 8'h00;

  // ----------------------------------------------------------------
  // Modes and control layout
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_UP     = 2'h0,
    MODE_DOWN   = 2'h1,
    MODE_CENTER = 2'h2
  } count_mode_t;

  typedef enum logic [1:0] {
    SRC_BUS  = 2'h0,
    SRC_LSO  = 2'h1,
    SRC_ENC  = 2'h2,
    SRC_LINK = 2'h3
  } clk_src_t;

  typedef enum logic [1:0] {
    CH_OFF     = 2'h0,
    CH_CAPTURE = 2'h1,
    CH_PWM     = 2'h2,
    CH_TOGGLE  = 2'h3
  } ch_mode_t;

  // Bit 0 is enable, bits 8:1 follow upward in declaration order reversed
  typedef struct packed {
    logic        hall;
    logic        link_rst;
    clk_src_t    src;
    logic        freeze;
    logic        one_pulse;
    count_mode_t mode;
    logic        en;
  } ctrl_t;

  localparam ctrl_t CTRL_RST = ctrl_t'(9'h000);

endpackage

// *** dv/far_side_model.sv ***
`timescale 1ns/10ps
// ------------------------------------------
// Encoder, hall sensors, link peer, slow osc
// ------------------------------------------
module far_side_model (
  // Clock
  input  wire logic       i_clk,
  // Towards the timers
  output logic      [3:0] o_ch_in,
  output logic            o_link_trg,
  output logic            o_lso
);
  int ph;

  // Idle levels at time zero
  initial begin
    o_ch_in    = 4'h0;
    o_link_trg = 1'b0;
    o_lso      = 1'b0;
    ph         = 0;
  end

  // Gray steps, A on bit 0 leads when forward; slow so no level is missed
  task automatic quad(input int n, input bit fwd);
    for (int i = 0; i < n; i++) begin
      ph = fwd ? (ph + 1) % 4 : (ph + 3) % 4;
      repeat (4) @(posedge i_clk);
      o_ch_in[1:0] <= (ph == 0) ? 2'h0 : (ph == 1) ? 2'h1 : (ph == 2) ? 2'h3 : 2'h2;
    end
  endtask

  // One pulse on a channel input, wide enough to be sampled
  task automatic edge_on(input int ch);
    @(posedge i_clk);
    o_ch_in[ch] <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_ch_in[ch] <= 1'b0;
  endtask

  // Single-cycle trigger events from a peer timer
  task automatic link_pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      o_link_trg <= 1'b1;
      @(posedge i_clk);
      o_link_trg <= 1'b0;
    end
  endtask

  // Slow oscillator, far below the bus clock
  task automatic lso_edges(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (10) @(posedge i_clk);
      o_lso <= 1'b1;
      repeat (10) @(posedge i_clk);
      o_lso <= 1'b0;
    end
  endtask
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  // ------------------------------------------
  // Signals; index 0 full timer, 1 reduced
  // ------------------------------------------
  logic        clk;
  logic        rst_b;
  logic [1:0]  psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        dbg_halt;
  logic [31:0] prdata [2];
  logic [3:0]  ch_out [2];
  logic [1:0]  pready;
  logic [1:0]  pslverr;
  logic [1:0]  trgo;
  logic [1:0]  dma;
  logic [1:0]  uflag;
  logic [3:0]  ch_in;
  logic        link_in;
  logic        lso;
  logic [31:0] rv;
  logic [31:0] r0;
  logic        ev;
  int          n_errors;
  int          checks;
  int          n_dma;

  // Reduced timer's updates chain into the full timer
  for (genvar g = 0; g < 2; g++) begin : g_tmr
    general_purpose_timer #(
      .FULL (g == 0)
    ) u_dut (
      .i_clk               (clk),
      .i_rst_b             (rst_b),
      .i_psel              (psel[g]),
      .i_penable           (penable),
      .i_pwrite            (pwrite),
      .i_paddr             (paddr),
      .i_pwdata            (pwdata),
      .o_prdata            (prdata[g]),
      .o_pready            (pready[g]),
      .o_pslverr           (pslverr[g]),
      .i_low_speed_ext_osc (lso),
      .i_dbg_halt          (dbg_halt),
      .i_link_trg          ((g == 0) ? trgo[1] : link_in),
      .o_link_trgo         (trgo[g]),
      .i_ch_in             (ch_in),
      .o_ch_out            (ch_out[g]),
      .o_dma_req           (dma[g]),
      .o_update_flag       (uflag[g])
    );
  end

  far_side_model u_far (
    .i_clk      (clk),
    .o_ch_in    (ch_in),
    .o_link_trg (link_in),
    .o_lso      (lso)
  );

  // 50 MHz clock
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // DMA pulses of the full timer
  always @(posedge clk) begin
    if (dma[0] === 1'b1) begin
      n_dma++;
    end
  end

  // ------------------------------------------
  // Tasks
  // ------------------------------------------
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // One APB transfer; the idle cycle after it keeps drivers single per step
  task automatic apb(input int u, input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel[u] <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready[u] !== 1'b1 && k < 20);
    rv = prdata[u];
    ev = pslverr[u];
    psel    <= 2'h0;
    penable <= 1'b0;
    @(posedge clk);
    if (k >= 20) begin
      chk(32'h0, 32'h1, "no ready");
      give_verdict();
    end
  endtask

  task automatic wr(input int u, input logic [7:0] a, input logic [31:0] d);
    apb(u, 1'b1, a, d);
  endtask

  task automatic rd(input int u, input logic [7:0] a, input logic [31:0] e, input string m);
    apb(u, 1'b0, a, 32'h0);
    chk({31'h0, ev}, 32'h0, m);
    chk(rv, e, m);
  endtask

  // Cycles between two update pulses; bounded waits
  task automatic period(input int exp);
    int p;
    p = 0;
    while (trgo[0] !== 1'b1 && p < 500) begin
      @(posedge clk);
      p++;
    end
    if (p >= 500) begin
      chk(32'h0, 32'h1, "no update");
      give_verdict();
    end
    p = 0;
    do begin
      @(posedge clk);
      p++;
    end while (trgo[0] !== 1'b1 && p < 500);
    chk(32'(p), 32'(exp), "update period");
    if (p >= 500) begin
      give_verdict();
    end
  endtask

  // ------------------------------------------
  // Sequence
  // ------------------------------------------
  initial begin
    rst_b    = 1'b0;
    psel     = 2'h0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0;
    dbg_halt = 1'b0;
    n_errors = 0;
    checks   = 0;
    n_dma    = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // Reset values on both timers
    for (int u = 0; u < 2; u++) begin
      rd(u, gp_timer_pkg::OFF_CTRL, 32'h0, "ctrl");
      rd(u, gp_timer_pkg::OFF_COUNT, 32'h0, "count");
      rd(u, gp_timer_pkg::OFF_PRESC, {16'h0, gp_timer_pkg::PRESC_RST}, "presc");
      rd(u, gp_timer_pkg::OFF_RELOAD, {16'h0, gp_timer_pkg::RELOAD_RST}, "reload");
    end
    // Unmapped places are refused
    apb(1, 1'b1, gp_timer_pkg::OFF_DMAEN, 32'h1);
    chk({31'h0, ev}, 32'h1, "dma reg on reduced");
    apb(1, 1'b0, 8'h20, 32'h0);
    chk({31'h0, ev}, 32'h1, "ccr2 on reduced");
    apb(0, 1'b0, 8'h2c, 32'h0);
    chk({31'h0, ev}, 32'h1, "unmapped");
    // Link events count on reduced, its updates chain into the full timer
    wr(1, gp_timer_pkg::OFF_RELOAD, 32'h1);
    wr(1, gp_timer_pkg::OFF_CTRL, 32'h61);
    wr(0, gp_timer_pkg::OFF_CTRL, 32'h61);
    u_far.link_pulses(6);
    repeat (4) @(posedge clk);
    rd(1, gp_timer_pkg::OFF_COUNT, 32'h0, "link count");
    rd(0, gp_timer_pkg::OFF_COUNT, 32'h3, "chained");
    // A chained update with counter reset enabled clears the count
    wr(0, gp_timer_pkg::OFF_CTRL, 32'he1);
    u_far.link_pulses(2);
    repeat (4) @(posedge clk);
    rd(0, gp_timer_pkg::OFF_COUNT, 32'h0, "link reset");
    // Reduced timer counts slow oscillator edges
    wr(1, gp_timer_pkg::OFF_RELOAD, 32'hffff);
    wr(1, gp_timer_pkg::OFF_CTRL, 32'h21);
    u_far.lso_edges(4);
    rd(1, gp_timer_pkg::OFF_COUNT, 32'h4, "slow osc");
    // Up, down and center periods, then prescaled
    wr(0, gp_timer_pkg::OFF_RELOAD, 32'h3);
    for (int m = 0; m < 3; m++) begin
      wr(0, gp_timer_pkg::OFF_CTRL, 32'h1 | 32'(m << 1));
      period((m == 2) ? 3 : 4);
      // Center mode is caught just after its turn at the top, so it reads down
      apb(0, 1'b0, gp_timer_pkg::OFF_STATUS, 32'h0);
      chk({31'h0, rv[5]}, {31'h0, m != 0}, "direction");
    end
    wr(0, gp_timer_pkg::OFF_PRESC, 32'h4);
    wr(0, gp_timer_pkg::OFF_CTRL, 32'h1);
    period(20);
    wr(0, gp_timer_pkg::OFF_PRESC, 32'h0);
    wr(0, gp_timer_pkg::OFF_CTRL, 32'h0);
    chk({31'h0, uflag[0]}, 32'h1, "flag set");
    wr(0, gp_timer_pkg::OFF_STATUS, 32'h1);
    chk({31'h0, uflag[0]}, 32'h0, "flag clear");
    // One pulse stops at the first update, counter wrapped to 0
    wr(0, gp_timer_pkg::OFF_CTRL, 32'h9);
    repeat (10) @(posedge clk);
    rd(0, gp_timer_pkg::OFF_CTRL, 32'h8, "one pulse");
    rd(0, gp_timer_pkg::OFF_COUNT, 32'h0, "one pulse count");
    // PWM on every live channel, high while count is below its compare value; reduced timer's channels 2 and 3 stay low
    for (int u = 0; u < 2; u++) begin
      wr(u, gp_timer_pkg::OFF_RELOAD, 32'h3);
      wr(u, gp_timer_pkg::OFF_CHMODE, 32'haa);
      for (int c = 0; c < 4; c++) begin
        wr(u, gp_timer_pkg::OFF_CCR0 + 8'(c * 4), 32'((c + 1) % 4));
      end
      wr(u, gp_timer_pkg::OFF_CTRL, 32'h1);
      for (int c = 0; c < 4; c++) begin
        r0 = 32'h0;
        repeat (8) begin
          @(posedge clk);
          r0 = r0 + {31'h0, ch_out[u][c] === 1'b1};
        end
        chk(r0, (u == 1 && c > 1) ? 32'h0 : 32'(((c + 1) % 4) * 2), "pwm");
      end
      wr(u, gp_timer_pkg::OFF_CTRL, 32'h0);
    end
    // Frozen counter in debug halt, capture with DMA request
    wr(0, gp_timer_pkg::OFF_DMAEN, 32'h1);
    wr(0, gp_timer_pkg::OFF_COUNT, 32'h0123);
    wr(0, gp_timer_pkg::OFF_CHMODE, 32'h05);
    dbg_halt <= 1'b1;
    wr(0, gp_timer_pkg::OFF_CTRL, 32'h11);
    n_dma = 0;
    repeat (6) @(posedge clk);
    rd(0, gp_timer_pkg::OFF_COUNT, 32'h0123, "frozen");
    u_far.edge_on(1);
    rd(0, gp_timer_pkg::OFF_CCR0 + gp_timer_pkg::CCR_STEP, 32'h0123, "capture");
    chk(32'(n_dma), 32'h1, "dma pulses");
    apb(0, 1'b0, gp_timer_pkg::OFF_STATUS, 32'h0);
    chk({31'h0, rv[2]}, 32'h1, "capture flag");
    // Hall change captures into channel 0
    wr(0, gp_timer_pkg::OFF_CTRL, 32'h111);
    wr(0, gp_timer_pkg::OFF_COUNT, 32'h0055);
    u_far.edge_on(2);
    rd(0, gp_timer_pkg::OFF_CCR0, 32'h0055, "hall");
    dbg_halt <= 1'b0;
    apb(0, 1'b0, gp_timer_pkg::OFF_COUNT, 32'h0);
    r0 = rv;
    apb(0, 1'b0, gp_timer_pkg::OFF_COUNT, 32'h0);
    chk({31'h0, rv !== r0}, 32'h1, "released");
    // Toggle on compare: square wave of twice the period, half of any 8 cycles high
    wr(0, gp_timer_pkg::OFF_CHMODE, 32'h35);
    r0 = 32'h0;
    repeat (8) begin
      @(posedge clk);
      r0 = r0 + {31'h0, ch_out[0][2] === 1'b1};
    end
    chk(r0, 32'h4, "toggle");
    // Encoder: B leading counts up, A leading counts down
    wr(0, gp_timer_pkg::OFF_RELOAD, 32'hffff);
    wr(0, gp_timer_pkg::OFF_COUNT, 32'h0100);
    wr(0, gp_timer_pkg::OFF_CTRL, 32'h41);
    u_far.quad(8, 1'b0);
    apb(0, 1'b0, gp_timer_pkg::OFF_COUNT, 32'h0);
    chk({31'h0, rv > 32'h100}, 32'h1, "enc up");
    r0 = rv;
    u_far.quad(8, 1'b1);
    apb(0, 1'b0, gp_timer_pkg::OFF_COUNT, 32'h0);
    chk({31'h0, rv < r0}, 32'h1, "enc down");
    give_verdict();
  end
endmodule
